/* rtl/cascaded_event_counter_capture.sv */
// Cascaded 24-bit event counter with capture, APB register slave
// How it works
// - Selected trigger edge copies count to first register
// - Primary pin edge copies count to second register
// - Reverse-edge first capture raises no interrupt
// - Byte counter counts valid event pin edges
// - Byte match clears counter, pulses wide counter
// - Byte clock select picks event edge
// - Gate select bit holds event input while gating timer output low
// - Select seven clocks wide counter from byte match
// - Both op bits set start clear-and-start
// - First match clears wide counter, interrupts
// - Wide counter counts only to first register
// - Second match still raises its interrupt
// - Gating timer interrupts at period end
// - Event input enabled only while gate high
// - First wide count clock after start dropped
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module cascaded_event_counter_capture
  import ecc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_input_pin,
  input wire logic primary_capture_pin,
  input wire logic secondary_capture_pin,
  output logic timer_out,
  output logic gate_level,
  output logic first_match_irq,
  output logic second_match_irq,
  output logic byte_match_irq,
  output logic gating_timer_irq
);
  gating_if gif ();

  logic [7:0] wide_mode_control;
  logic [7:0] capcmp_control;
  logic [7:0] timer_output_control;
  logic [7:0] wide_prescaler_select;
  logic [15:0] wide_counter;
  logic [15:0] first_capcmp_reg;
  logic [15:0] second_capcmp_reg;
  logic [7:0] byte_event_counter;
  logic [7:0] byte_compare_reg;
  logic [7:0] byte_clock_select;
  logic [7:0] byte_mode_control;
  logic [7:0] gating_mode_reg;
  logic [7:0] gating_period_cmp;
  logic [7:0] gating_duty_cmp;
  logic [7:0] input_switch_control;
  logic [4:0] status;

  logic wr;
  logic setup;
  logic [1:0] op;
  logic [2:0] sel;
  logic armed;
  logic [7:0] pre;
  logic [7:0] pre_mask;
  logic tick;
  logic byte_match;
  logic ev_en;
  logic ev_gated;
  logic ev_prev;
  logic byte_edge;
  logic pri_prev;
  logic sec_prev;
  logic pri_valid;
  logic pri_rev;
  logic sec_valid;
  logic first_trig;
  logic first_cmp_hit;
  logic second_cmp_hit;
  logic ovf_hit;
  logic [31:0] next_prdata;
  logic next_slverr;

  // Edge classification by a two-bit edge code
  function automatic logic edge_hit(input logic [1:0] code, input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now && !was;
    fall = !now && was;
    unique case (code)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign op = wide_mode_control[WM_OP_LO+1:WM_OP_LO];
  assign sel = wide_prescaler_select[2:0];

  assign gif.enable = gating_mode_reg[GM_ENABLE];
  assign gif.level = gating_mode_reg[GM_LEVEL];
  assign gif.out_en = gating_mode_reg[GM_OUT_EN];
  assign gif.clk_sel = gating_mode_reg[GM_CLK+2:GM_CLK];
  assign gif.period = gating_period_cmp;
  assign gif.duty = gating_duty_cmp;
  assign gate_level = gif.gate;
  assign gating_timer_irq = gif.irq;

  gating_pwm_timer u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .g(gif.timer)
  );

  assign ev_en = !input_switch_control[ISC_GATE] || gif.gate;
  // Hold level while closed
  // Holding instead of ANDing keeps a closing window from faking an edge
  assign ev_gated = ev_en ? event_input_pin : ev_prev;
  assign byte_edge = byte_mode_control[BM_ENABLE] && (byte_clock_select == BYTE_CLK_RISE ?
    (ev_gated && !ev_prev) : (!ev_gated && ev_prev));

  assign pri_valid = edge_hit(wide_prescaler_select[PS_PRI_EDGE+1:PS_PRI_EDGE],
    primary_capture_pin, pri_prev);
  assign pri_rev = edge_hit(wide_prescaler_select[PS_PRI_EDGE+1:PS_PRI_EDGE] ^ 2'b01,
    primary_capture_pin, pri_prev) && !wide_prescaler_select[PS_PRI_EDGE+1];
  assign sec_valid = edge_hit(wide_prescaler_select[PS_SEC_EDGE+1:PS_SEC_EDGE],
    secondary_capture_pin, sec_prev);
  assign first_trig = capcmp_control[CC_FIRST_REV] ? pri_rev : sec_valid;

  // Prescaled count clock, or cascade from the byte counter
  assign pre_mask = 8'((16'h0001 << sel) - 16'h0001);
  assign tick = (op != OP_STOP) && (sel == SEL_CASCADE ? byte_match :
    ((pre & pre_mask) == 8'h00));
  assign first_cmp_hit = tick && armed && !capcmp_control[CC_FIRST_CAP] &&
    wide_counter == first_capcmp_reg;
  assign second_cmp_hit = tick && armed && !capcmp_control[CC_SECOND_CAP] &&
    wide_counter == second_capcmp_reg;
  assign ovf_hit = tick && armed && wide_counter == 16'hFFFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_prev <= 1'b0;
      pri_prev <= 1'b0;
      sec_prev <= 1'b0;
      pre <= 8'h00;
    end else begin
      ev_prev <= ev_gated;
      pri_prev <= primary_capture_pin;
      sec_prev <= secondary_capture_pin;
      pre <= (op == OP_STOP) ? 8'h00 : pre + 8'h01;
    end
  end

  // Byte event counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_event_counter <= RST_REG8;
      byte_match <= 1'b0;
    end else begin
      byte_match <= 1'b0;
      if (!byte_mode_control[BM_ENABLE]) begin
        byte_event_counter <= RST_REG8;
      end else if (byte_edge && byte_event_counter == byte_compare_reg) begin
        byte_event_counter <= 8'h00;
        byte_match <= 1'b1;
      end else if (byte_edge) begin
        byte_event_counter <= byte_event_counter + 8'h01;
      end
    end
  end
  assign byte_match_irq = byte_match;

  // Wide counter with start synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_counter <= 16'h0000;
      armed <= 1'b0;
    end else if (op == OP_STOP) begin
      wide_counter <= 16'h0000;
      armed <= 1'b0;
    end else if (op == OP_PIN_CLEAR && pri_valid) begin
      wide_counter <= 16'h0000;
    end else if (tick && !armed) begin
      armed <= 1'b1;
    end else if (op == OP_CLEAR_START && first_cmp_hit) begin
      wide_counter <= 16'h0000;
    end else if (tick) begin
      wide_counter <= wide_counter + 16'h0001;
    end
  end

  // First register: capture or compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_capcmp_reg <= RST_CMP16;
    end else if (capcmp_control[CC_FIRST_CAP] && op != OP_STOP && first_trig) begin
      first_capcmp_reg <= wide_counter;
    end else if (wr && paddr == OFF_FIRST_REG) begin
      first_capcmp_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_capcmp_reg <= RST_CMP16;
    end else if (capcmp_control[CC_SECOND_CAP] && op != OP_STOP && pri_valid) begin
      second_capcmp_reg <= wide_counter;
    end else if (wr && paddr == OFF_SECOND_REG) begin
      second_capcmp_reg <= pwdata[15:0];
    end
  end

  // Interrupt pulses toward the system controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_match_irq <= 1'b0;
      second_match_irq <= 1'b0;
    end else begin
      first_match_irq <= first_cmp_hit || (capcmp_control[CC_FIRST_CAP] &&
        !capcmp_control[CC_FIRST_REV] && op != OP_STOP && first_trig);
      second_match_irq <= second_cmp_hit ||
        (capcmp_control[CC_SECOND_CAP] && op != OP_STOP && pri_valid);
    end
  end

  // Timer output toggles on first match when enable and invert bits are both set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out <= 1'b0;
    end else if (first_cmp_hit && timer_output_control[TOC_ENABLE] &&
      timer_output_control[TOC_INVERT]) begin
      timer_out <= !timer_out;
    end
  end

  // Sticky status, set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 5'h00;
    end else begin
      status <= (status & ~((wr && paddr == OFF_STATUS) ? pwdata[4:0] : 5'h00)) |
        {ovf_hit, gif.irq, byte_match, second_match_irq, first_match_irq};
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_mode_control <= RST_REG8;
      capcmp_control <= RST_REG8;
      timer_output_control <= RST_REG8;
      wide_prescaler_select <= RST_REG8;
      byte_compare_reg <= RST_CMP8;
      byte_clock_select <= RST_REG8;
      byte_mode_control <= RST_REG8;
      gating_mode_reg <= RST_REG8;
      gating_period_cmp <= RST_CMP8;
      gating_duty_cmp <= RST_REG8;
      input_switch_control <= RST_REG8;
    end else if (wr) begin
      unique case (paddr)
        OFF_WIDE_MODE: wide_mode_control <= pwdata[7:0];
        OFF_CAPCMP: capcmp_control <= pwdata[7:0];
        OFF_TOC: timer_output_control <= pwdata[7:0];
        OFF_PRESCALE: wide_prescaler_select <= pwdata[7:0];
        OFF_BYTE_CMP: byte_compare_reg <= pwdata[7:0];
        OFF_BYTE_CLK: byte_clock_select <= pwdata[7:0];
        OFF_BYTE_MODE: byte_mode_control <= pwdata[7:0];
        OFF_GATE_MODE: gating_mode_reg <= pwdata[7:0];
        OFF_GATE_PERIOD: gating_period_cmp <= pwdata[7:0];
        OFF_GATE_DUTY: gating_duty_cmp <= pwdata[7:0];
        OFF_ISC: input_switch_control <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux, sampled in the setup cycle so read data comes from a flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    unique case (paddr)
      OFF_WIDE_MODE: next_prdata[7:0] = wide_mode_control;
      OFF_CAPCMP: next_prdata[7:0] = capcmp_control;
      OFF_TOC: next_prdata[7:0] = timer_output_control;
      OFF_PRESCALE: next_prdata[7:0] = wide_prescaler_select;
      OFF_WIDE_CNT: next_prdata[15:0] = wide_counter;
      OFF_FIRST_REG: next_prdata[15:0] = first_capcmp_reg;
      OFF_SECOND_REG: next_prdata[15:0] = second_capcmp_reg;
      OFF_BYTE_CNT: next_prdata[7:0] = byte_event_counter;
      OFF_BYTE_CMP: next_prdata[7:0] = byte_compare_reg;
      OFF_BYTE_CLK: next_prdata[7:0] = byte_clock_select;
      OFF_BYTE_MODE: next_prdata[7:0] = byte_mode_control;
      OFF_GATE_MODE: next_prdata[7:0] = gating_mode_reg;
      OFF_GATE_PERIOD: next_prdata[7:0] = gating_period_cmp;
      OFF_GATE_DUTY: next_prdata[7:0] = gating_duty_cmp;
      OFF_ISC: next_prdata[7:0] = input_switch_control;
      OFF_STATUS: next_prdata[4:0] = status;
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= next_prdata;
      pslverr <= next_slverr;
    end
  end

  a_byte_count_up: assert property (
    @(posedge pclk) disable iff (!presetn)
    (byte_edge && byte_event_counter != byte_compare_reg) |=>
      (byte_event_counter == $past(byte_event_counter) + 8'h01))
    else $error("byte counter missed an edge");

  a_byte_wrap_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (byte_edge && byte_event_counter == byte_compare_reg) |=>
      (byte_event_counter == 8'h00 && byte_match))
    else $error("byte match did not clear and pulse");

  a_gate_blocks_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (input_switch_control[ISC_GATE] && !gif.gate) |-> !byte_edge)
    else $error("edge passed a closed window");

  a_cascade_clock: assert property (
    @(posedge pclk) disable iff (!presetn)
    (op == OP_CLEAR_START && $past(op) == OP_CLEAR_START && sel == SEL_CASCADE &&
      !byte_match) |=> (wide_counter == $past(wide_counter)))
    else $error("wide counter moved without cascade pulse");

  a_first_clock_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && !armed && !(op == OP_PIN_CLEAR && pri_valid)) |=>
      (armed && wide_counter == $past(wide_counter)))
    else $error("first count clock was not dropped");

  a_clear_on_match: assert property (
    @(posedge pclk) disable iff (!presetn)
    (op == OP_CLEAR_START && first_cmp_hit) |=> (wide_counter == 16'h0000 && first_match_irq))
    else $error("first match did not clear and interrupt");

  a_second_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    (capcmp_control[CC_SECOND_CAP] && op != OP_STOP && pri_valid) |=>
      (second_capcmp_reg == $past(wide_counter) && second_match_irq))
    else $error("second capture missed");

  a_first_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    (capcmp_control[CC_FIRST_CAP] && op != OP_STOP && first_trig) |=>
      (first_capcmp_reg == $past(wide_counter)))
    else $error("first capture missed");

  a_reverse_silent: assert property (
    @(posedge pclk) disable iff (!presetn)
    (capcmp_control[CC_FIRST_CAP] && capcmp_control[CC_FIRST_REV]) [*2] |-> !first_match_irq)
    else $error("reverse-edge capture raised interrupt");

  a_second_cmp_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    second_cmp_hit |=> second_match_irq ##1 status[ST_SECOND])
    else $error("second compare interrupt missing");
endmodule : cascaded_event_counter_capture

/* rtl/ecc_pkg.sv */
// Constants for the cascaded event counter with capture
package ecc_pkg;
  // Register byte addresses
  localparam logic [7:0] OFF_WIDE_MODE = 8'h00;
  localparam logic [7:0] OFF_CAPCMP = 8'h04;
  localparam logic [7:0] OFF_TOC = 8'h08;
  localparam logic [7:0] OFF_PRESCALE = 8'h0C;
  localparam logic [7:0] OFF_WIDE_CNT = 8'h10;
  localparam logic [7:0] OFF_FIRST_REG = 8'h14;
  localparam logic [7:0] OFF_SECOND_REG = 8'h18;
  localparam logic [7:0] OFF_BYTE_CNT = 8'h1C;
  localparam logic [7:0] OFF_BYTE_CMP = 8'h20;
  localparam logic [7:0] OFF_BYTE_CLK = 8'h24;
  localparam logic [7:0] OFF_BYTE_MODE = 8'h28;
  localparam logic [7:0] OFF_GATE_MODE = 8'h2C;
  localparam logic [7:0] OFF_GATE_PERIOD = 8'h30;
  localparam logic [7:0] OFF_GATE_DUTY = 8'h34;
  localparam logic [7:0] OFF_ISC = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;
  // Field positions
  localparam int WM_OP_LO = 2;
  localparam int CC_FIRST_CAP = 0;
  localparam int CC_FIRST_REV = 1;
  localparam int CC_SECOND_CAP = 2;
  localparam int TOC_ENABLE = 0;
  localparam int TOC_INVERT = 1;
  localparam int PS_PRI_EDGE = 4;
  localparam int PS_SEC_EDGE = 6;
  localparam int BM_ENABLE = 7;
  localparam int GM_OUT_EN = 0;
  localparam int GM_LEVEL = 1;
  localparam int GM_CLK = 4;
  localparam int GM_ENABLE = 7;
  localparam int ISC_GATE = 2;
  localparam int ST_FIRST = 0;
  localparam int ST_SECOND = 1;
  localparam int ST_BYTE = 2;
  localparam int ST_GATE = 3;
  localparam int ST_OVF = 4;
  // Encodings
  localparam logic [1:0] OP_STOP = 2'b00;
  localparam logic [1:0] OP_FREE = 2'b01;
  localparam logic [1:0] OP_PIN_CLEAR = 2'b10;
  localparam logic [1:0] OP_CLEAR_START = 2'b11;
  localparam logic [2:0] SEL_CASCADE = 3'h7;
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b10;
  localparam logic [7:0] BYTE_CLK_RISE = 8'h01;
  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] RST_CMP16 = 16'hFFFF;
  localparam logic [7:0] RST_CMP8 = 8'hFF;
endpackage : ecc_pkg

/* rtl/gating_if.sv */
// Control and output of the gating PWM timer
`timescale 1ns/1ns
interface gating_if;
  logic enable;
  logic level;
  logic out_en;
  logic [2:0] clk_sel;
  logic [7:0] period;
  logic [7:0] duty;
  logic gate;
  logic irq;
  modport ctrl (output enable, level, out_en, clk_sel, period, duty, input gate, irq);
  modport timer (input enable, level, out_en, clk_sel, period, duty, output gate, irq);
endinterface : gating_if

/* rtl/gating_pwm_timer.sv */
// Gating PWM timer that opens and closes the event input window
`timescale 1ns/1ns
module gating_pwm_timer
  import ecc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  gating_if.timer g
);
  logic [11:0] pre;
  logic [7:0] cnt;
  logic out;
  logic tick;
  logic [11:0] mask;

  assign mask = 12'((16'h0001 << (2 * g.clk_sel)) - 16'h0001);
  assign tick = g.enable && ((pre & mask) == 12'h000);
  assign g.gate = g.out_en ? out : g.level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 12'h000;
    end else begin
      pre <= g.enable ? pre + 12'h001 : 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      out <= 1'b1;
      g.irq <= 1'b0;
    end else begin
      g.irq <= 1'b0;
      if (!g.enable) begin
        cnt <= 8'h00;
        out <= g.level;
      end else if (tick && cnt == g.period) begin
        // Window closes at period end when the level bit is set, so software reads a frozen count
        cnt <= 8'h00;
        out <= ~g.level;
        g.irq <= 1'b1;
      end else if (tick) begin
        cnt <= cnt + 8'h01;
        if (cnt == g.duty) begin
          out <= g.level;
        end
      end
    end
  end

  a_gate_period_end: assert property (
    @(posedge pclk) disable iff (!presetn)
    (g.enable && tick && cnt == g.period) |=> (g.irq && cnt == 8'h00 && out == ~g.level))
    else $error("gating timer missed period end");
endmodule : gating_pwm_timer

/* bench/pulse_source.sv */
// External pulse source driving the event and capture pins
`timescale 1ns/1ns
module pulse_source (
  input wire logic pclk,
  output logic event_pin,
  output logic pri_pin,
  output logic sec_pin
);
  // Pins idle low; index 0 event, 1 primary, 2 secondary
  logic [2:0] lvl = 3'b000;
  assign event_pin = lvl[0];
  assign pri_pin = lvl[1];
  assign sec_pin = lvl[2];
  // Levels change only after an edge, so sampling never races
  task automatic pulse(input int which, input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge pclk);
      lvl[which] <= 1'b1;
      repeat (hold) @(posedge pclk);
      lvl[which] <= 1'b0;
    end
  endtask : pulse
  task automatic set(input int which, input logic v);
    @(posedge pclk);
    lvl[which] <= v;
  endtask : set
endmodule : pulse_source

/* bench/testbench.sv */
// Self-checking bench for the cascaded event counter
`timescale 1ns/1ns
module testbench;
  import ecc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, f0;
  logic pready, pslverr, err, ev, pri, sec, tout, gate, irq1, irq2, irqb, irqg;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 32'h86d6591a;
  int c1 = 0, c2 = 0, cb = 0, cg = 0;
  always #5 pclk = ~pclk;
  // Irq pulses last one cycle, so count them at every edge
  always @(posedge pclk) begin
    c1 <= c1 + int'(irq1 === 1'b1);
    c2 <= c2 + int'(irq2 === 1'b1);
    cb <= cb + int'(irqb === 1'b1);
    cg <= cg + int'(irqg === 1'b1);
  end
  cascaded_event_counter_capture i_cascaded_event_counter_capture (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_pin(ev), .primary_capture_pin(pri), .secondary_capture_pin(sec),
    .timer_out(tout), .gate_level(gate), .first_match_irq(irq1), .second_match_irq(irq2),
    .byte_match_irq(irqb), .gating_timer_irq(irqg));
  pulse_source i_pulse_source (.pclk(pclk), .event_pin(ev), .pri_pin(pri), .sec_pin(sec));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, rd, e);
  endtask : rdchk
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  function automatic logic [31:0] exp_events(input int n, input int extra);
    return 32'((n + extra) % 256);
  endfunction : exp_events
  // First wide clock after start is swallowed
  function automatic logic [31:0] exp_wide(input int n);
    return 32'(n / 256 - 1);
  endfunction : exp_wide
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
  initial begin
    int n, m;
    do_reset();
    rdchk("byte_cmp", OFF_BYTE_CMP, 32'(RST_CMP8));
    rdchk("first_reg", OFF_FIRST_REG, 32'(RST_CMP16));
    rdchk("toc", OFF_TOC, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    chk("pslverr", 32'(err), 32'h1);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      n = 1 + ($random(seed) & 8'h3F);
      wr(OFF_BYTE_CLK, 32'(k));
      wr(OFF_BYTE_MODE, 32'h80);
      i_pulse_source.pulse(0, n, 2);
      i_pulse_source.set(0, 1'b1);
      repeat (4) @(posedge pclk);
      rdchk("byte_cnt", OFF_BYTE_CNT, exp_events(n, k));
      i_pulse_source.set(0, 1'b0);
    end
    $display("test edge select done");
    for (int j = 0; j < 2; j++) begin
      do_reset();
      wr(OFF_TOC, 32'h0);
      wr(OFF_CAPCMP, 32'h0);
      wr(OFF_PRESCALE, 32'(SEL_CASCADE));
      wr(OFF_BYTE_CMP, 32'hFF);
      wr(OFF_BYTE_CLK, 32'(BYTE_CLK_RISE));
      wr(OFF_FIRST_REG, (j == 1) ? 32'h1 : 32'hFFFF);
      wr(OFF_SECOND_REG, (j == 1) ? 32'h1 : 32'hFFFF);
      wr(OFF_WIDE_MODE, 32'(OP_CLEAR_START) << WM_OP_LO);
      wr(OFF_BYTE_MODE, 32'h80);
      n = cb;
      m = c1;
      f0 = 32'(c2);
      i_pulse_source.pulse(0, 773, 2);
      repeat (4) @(posedge pclk);
      if (j == 0) begin
        rdchk("byte_cnt", OFF_BYTE_CNT, exp_events(773, 0));
        rdchk("wide_cnt", OFF_WIDE_CNT, exp_wide(773));
        chk("byte_irqs", 32'(cb - n), 32'd3);
        rdchk("status", OFF_STATUS, 32'h1 << ST_BYTE);
      end else begin
        apb(1'b0, OFF_WIDE_CNT, 32'h0);
        chk("wide_max", rd, 32'h0);
        chk("first_irq", 32'(c1 - m), 32'h1);
        chk("second_irq", 32'(c2) - f0, 32'h1);
        chk("timer_out", 32'(tout), 32'h0);
      end
    end
    $display("test cascade done");
    do_reset();
    wr(OFF_BYTE_CLK, 32'(BYTE_CLK_RISE));
    wr(OFF_BYTE_MODE, 32'h80);
    wr(OFF_ISC, 32'h1 << ISC_GATE);
    i_pulse_source.pulse(0, 5, 2);
    chk("gate_low", 32'(gate), 32'h0);
    wr(OFF_GATE_MODE, 32'h1 << GM_LEVEL);
    i_pulse_source.pulse(0, 7, 2);
    wr(OFF_ISC, 32'h0);
    wr(OFF_GATE_MODE, 32'h0);
    i_pulse_source.pulse(0, 3, 2);
    repeat (4) @(posedge pclk);
    rdchk("gated_cnt", OFF_BYTE_CNT, exp_events(10, 0));
    wr(OFF_GATE_PERIOD, 32'h10);
    wr(OFF_GATE_DUTY, 32'h04);
    n = cg;
    wr(OFF_GATE_MODE, 32'h83);
    repeat (200) @(posedge pclk);
    chk("gate_irqs", 32'(cg - n > 2), 32'h1);
    $display("test gating done");
    do_reset();
    wr(OFF_PRESCALE, 32'h10);
    wr(OFF_CAPCMP, 32'h07);
    wr(OFF_WIDE_MODE, 32'(OP_FREE) << WM_OP_LO);
    m = c1;
    n = c2;
    i_pulse_source.pulse(1, 1, 20);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_SECOND_REG, 32'h0);
    f0 = rd;
    apb(1'b0, OFF_FIRST_REG, 32'h0);
    chk("width", rd - f0, 32'd20);
    chk("second_cap_irq", 32'(c2 - n), 32'h1);
    chk("reverse_irq", 32'(c1 - m), 32'h0);
    f0 = rd;
    wr(OFF_PRESCALE, 32'h50);
    wr(OFF_CAPCMP, 32'h05);
    m = c1;
    i_pulse_source.pulse(2, 1, 2);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_FIRST_REG, 32'h0);
    chk("sec_capture", 32'(rd > f0), 32'h1);
    chk("sec_irq", 32'(c1 - m), 32'h1);
    wr(OFF_PRESCALE, 32'h20);
    wr(OFF_WIDE_MODE, 32'(OP_PIN_CLEAR) << WM_OP_LO);
    n = c2;
    i_pulse_source.pulse(1, 1, 10);
    repeat (4) @(posedge pclk);
    // Clearing edge itself adds no count
    rdchk("pin_clear_width", OFF_SECOND_REG, 32'd9);
    chk("both_edge_irqs", 32'(c2 - n), 32'h2);
    $display("test capture done");
    stop_test();
  end
endmodule : testbench
